// [hw/emb_block_top.sv]
// Embedded block: synchronous memory and product-term macrocells
//
// Behaviour
// - Each macrocell register acts as D, T, JK or SR, or is bypassed.
// - Each macrocell picks one of two block clocks, each with its own enable.
// - Both-edge use takes both clock lines, one rising, one falling.
// - Two optionally inverted clear lines; each macrocell picks one or none.
// - OR gate takes up to 32 terms: two own plus 30 borrowed.
// - Borrowed terms come in sets of two, at most 15 sets chained.
// - One product term per macrocell may be inverted.
// - Memory shapes 128x16, 256x8, 512x4, 1024x2 or 2048x1.
// - Write data, address and strobe are registered; write pulse made inside.
// - Optional read-data output register adds one pipeline stage.
// - Deep arrays decode upper address bits and drive shared line per page.
// - Page decode lets exactly one block drive the shared read line.
// - Read/write mode: write clock for write regs, read clock for read regs.
// - In that mode write regs use ceWr and clrWr; read and output regs share ceRd and clrRd.
// - Input/output mode: one clock for all inputs, other for output regs.
// - Memory registers clear by local, global signal or chip-wide reset.
// - Read and write proceed in one period on different clocks.
// - Single-port mode shares one clock and one address.
// - Two-way dual-port memory is built from two or four blocks.
// - Chip-wide reset overrides all controls and clears every register.
// - Sixteen macrocells, each with two own terms and one register.
`timescale 1ns/10ps

module emb_block_top (
  // Clock and chip-wide clear
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  // Block clock lines, sampled, with edge choice
  input  wire logic                                  clkLineA,
  input  wire logic                                  clkLineB,
  input  wire logic [1:0]                            lineFall,
  // Mode
  input  wire logic                                  memMode,
  input  wire emb_pkg::emb_port_e                    portMode,
  input  wire logic [2:0]                            aspect,
  input  wire logic                                  outRegEn,
  input  wire logic                                  deepEn,
  input  wire logic [1:0]                            pageSel,
  // Memory group controls
  input  wire logic                                  ceWr,
  input  wire logic                                  ceRd,
  input  wire logic                                  clrWr,
  input  wire logic                                  clrRd,
  input  wire logic                                  globalClr,
  // Memory ports
  input  wire logic [emb_pkg::DATA_W-1:0]            wrData,
  input  wire logic [emb_pkg::ADDR_W-1:0]            wrAddr,
  input  wire logic                                  wrStrobe,
  input  wire logic [emb_pkg::ADDR_W-1:0]            rdAddr,
  input  wire logic                                  readStrobe,
  output logic      [emb_pkg::DATA_W-1:0]            rdData,
  output logic                                       rdDrive,
  // Product-term controls
  input  wire logic                                  ceA,
  input  wire logic                                  ceB,
  input  wire logic [1:0]                            ptClr,
  input  wire logic [1:0]                            ptClrInv,
  // Per-macrocell configuration and terms
  input  wire logic [emb_pkg::MACROCELLS-1:0][1:0]   ptTerm,
  input  wire logic [emb_pkg::MACROCELLS-1:0][2:0]   mcType,
  input  wire logic [emb_pkg::MACROCELLS-1:0]        mcClkSel,
  input  wire logic [emb_pkg::MACROCELLS-1:0][1:0]   mcClrSel,
  input  wire logic [emb_pkg::MACROCELLS-1:0]        mcInvEn,
  input  wire logic [emb_pkg::MACROCELLS-1:0]        mcInvWhich,
  input  wire logic [emb_pkg::MACROCELLS-1:0][3:0]   mcSets,
  output logic      [emb_pkg::MACROCELLS-1:0]        mcOut
);

  typedef struct packed {
    logic [emb_pkg::BLOCK_BITS-1:0] mem;
    logic [emb_pkg::DATA_W-1:0]     wData;
    logic [emb_pkg::ADDR_W-1:0]     wAddr;
    logic                           wPend;
    logic [emb_pkg::ADDR_W-1:0]     rAddr;
    logic [emb_pkg::DATA_W-1:0]     rWord;
    logic [emb_pkg::DATA_W-1:0]     outWord;
    logic [emb_pkg::MACROCELLS-1:0] mcQ;
    logic                           prevA;
    logic                           prevB;
  } emb_state_s;

  emb_state_s state_r;
  emb_state_s state_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock line edges and group controls

  logic                             tickA;
  logic                             tickB;
  logic                             rTick;
  logic                             oTick;
  logic                             rCe;
  logic                             wClr;
  logic                             rClr;
  logic                             oClr;
  logic [1:0]                       clrLine;
  logic [emb_pkg::MACROCELLS-1:0]   t0;
  logic [emb_pkg::MACROCELLS-1:0]   t1;
  logic [emb_pkg::MACROCELLS-1:0]   mcSum;
  logic [emb_pkg::ADDR_W-1:0]       rAddrIn;

  // One line per edge when both edges are wanted
  assign tickA = lineFall[0] ? (state_r.prevA & ~clkLineA)
                             : (clkLineA & ~state_r.prevA);
  assign tickB = lineFall[1] ? (state_r.prevB & ~clkLineB)
                             : (clkLineB & ~state_r.prevB);

  // Read input regs follow the read clock only in read/write mode
  assign rTick   = (portMode == emb_pkg::EMB_RW_CLOCK) ? tickB : tickA;
  assign oTick   = (portMode == emb_pkg::EMB_SINGLE) ? tickA : tickB;
  assign rCe     = (portMode == emb_pkg::EMB_RW_CLOCK) ? ceRd : ceWr;
  assign wClr    = clrWr | globalClr;
  assign rClr    = ((portMode == emb_pkg::EMB_RW_CLOCK) ? clrRd : clrWr)
                   | globalClr;
  assign oClr    = clrRd | globalClr;
  assign rAddrIn = (portMode == emb_pkg::EMB_SINGLE) ? wrAddr : rdAddr;
  assign clrLine = ptClr ^ ptClrInv;

  ////////////////////////////////////////////////////////////////////////////////
  // Own product terms

  for (genvar i = 0; i < emb_pkg::MACROCELLS; i++) begin : g_terms
    assign t0[i] = ptTerm[i][0] ^ (mcInvEn[i] & ~mcInvWhich[i]);
    assign t1[i] = ptTerm[i][1] ^ (mcInvEn[i] & mcInvWhich[i]);
  end

  // Chained expander sets borrowed from the following macrocells
  always_comb begin
    mcSum = '0;
    for (int i = 0; i < emb_pkg::MACROCELLS; i++) begin
      mcSum[i] = t0[i] | t1[i];
      for (int k = 1; k <= emb_pkg::MAX_SETS; k++) begin
        if (4'(k) <= mcSets[i]) begin
          mcSum[i] = mcSum[i] | (|ptTerm[(i + k) % emb_pkg::MACROCELLS]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Word layout

  function automatic logic [10:0] word_base(input logic [10:0] a, input logic [2:0] asp);
    logic [2:0]  sh;
    logic [10:0] m;
    sh = emb_pkg::MAX_ASPECT - asp;
    m  = emb_pkg::FULL_MASK >> sh;
    return (a & m) << sh;
  endfunction

  function automatic logic [4:0] word_width(input logic [2:0] asp);
    return 5'h10 >> asp;
  endfunction

  logic        pageHit;
  logic [10:0] wBase;
  logic [10:0] rBase;

  assign pageHit = !deepEn || (state_r.wAddr[12:11] == pageSel);
  assign wBase   = word_base(state_r.wAddr[10:0], aspect);
  assign rBase   = word_base(rAddrIn[10:0], aspect);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic d;
    logic j;
    logic k;
    logic tk;
    logic cl;
    d  = 1'b0;
    j  = 1'b0;
    k  = 1'b0;
    tk = 1'b0;
    cl = 1'b0;
    state_nxt = state_r;
    state_nxt.prevA = clkLineA;
    state_nxt.prevB = clkLineB;
    // Write group: capture, then internal write pulse one cycle later
    state_nxt.wPend = 1'b0;
    if (state_r.wPend && pageHit) begin
      for (int b = 0; b < emb_pkg::DATA_W; b++) begin
        if (5'(b) < word_width(aspect)) begin
          state_nxt.mem[11'(wBase + 11'(b))] = state_r.wData[b];
        end
      end
    end
    if (wClr) begin
      state_nxt.wData = emb_pkg::WORD_RESET;
      state_nxt.wAddr = '0;
    end else if (memMode && tickA && ceWr) begin
      state_nxt.wData = wrData;
      state_nxt.wAddr = wrAddr;
      state_nxt.wPend = wrStrobe;
    end
    // Read group: old contents win on a same-cycle collision
    if (rClr) begin
      state_nxt.rAddr = '0;
      state_nxt.rWord = emb_pkg::WORD_RESET;
    end else if (memMode && rTick && rCe && readStrobe) begin
      state_nxt.rAddr = rAddrIn;
      for (int b = 0; b < emb_pkg::DATA_W; b++) begin
        state_nxt.rWord[b] = (5'(b) < word_width(aspect))
                             ? state_r.mem[11'(rBase + 11'(b))] : 1'b0;
      end
    end
    // Output group
    if (oClr) begin
      state_nxt.outWord = emb_pkg::WORD_RESET;
    end else if (oTick && ceRd) begin
      state_nxt.outWord = state_r.rWord;
    end
    // Macrocell registers
    for (int i = 0; i < emb_pkg::MACROCELLS; i++) begin
      d  = mcSum[i];
      j  = t0[i];
      k  = t1[i];
      tk = mcClkSel[i] ? (tickB & ceB) : (tickA & ceA);
      cl = (mcClrSel[i] == emb_pkg::CLR_LINE0 && clrLine[0])
        || (mcClrSel[i] == emb_pkg::CLR_LINE1 && clrLine[1]);
      if (cl) begin
        state_nxt.mcQ[i] = 1'b0;
      end else if (!memMode && tk) begin
        unique case (emb_pkg::emb_reg_e'(mcType[i]))
          emb_pkg::EMB_REG_D:      state_nxt.mcQ[i] = d;
          emb_pkg::EMB_REG_T:      state_nxt.mcQ[i] = state_r.mcQ[i] ^ d;
          emb_pkg::EMB_REG_JK:     state_nxt.mcQ[i] = (j & ~state_r.mcQ[i])
                                                    | (~k & state_r.mcQ[i]);
          emb_pkg::EMB_REG_SR:     state_nxt.mcQ[i] = j | (~k & state_r.mcQ[i]);
          emb_pkg::EMB_REG_BYPASS: state_nxt.mcQ[i] = state_r.mcQ[i];
          default:                 state_nxt.mcQ[i] = state_r.mcQ[i];
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdData = outRegEn ? state_r.outWord : state_r.rWord;
  // Distinct page codes per block give one driver per shared line
  assign rdDrive = memMode && (!deepEn || state_r.rAddr[12:11] == pageSel);
  // Each block is one port pair; two or four blocks form a two-way dual port

  always_comb begin
    for (int i = 0; i < emb_pkg::MACROCELLS; i++) begin
      mcOut[i] = (mcType[i] == emb_pkg::EMB_REG_BYPASS) ? mcSum[i] : state_r.mcQ[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_all: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> (state_r.mcQ == '0 && !state_r.wPend && state_r.rWord == '0))
    else $error("reset did not clear registers");
  a_bypass_path: assert property (
    mcType[0] == emb_pkg::EMB_REG_BYPASS |-> mcOut[0] == mcSum[0])
    else $error("bypass output not combinational");
  a_d_capture: assert property (
    !memMode && mcType[0] == emb_pkg::EMB_REG_D && !mcClkSel[0] && tickA && ceA
    && mcClrSel[0] == emb_pkg::CLR_NONE |=> state_r.mcQ[0] == $past(mcSum[0]))
    else $error("D register missed its clock");
  a_hold_no_ce: assert property (
    !ceA && !ceB && clrLine == 2'h0 |=> $stable(state_r.mcQ))
    else $error("macrocell changed without enable");
  a_clear_line: assert property (
    (mcClrSel[0] == emb_pkg::CLR_LINE0 && clrLine[0])
    || (mcClrSel[0] == emb_pkg::CLR_LINE1 && clrLine[1]) |=> !state_r.mcQ[0])
    else $error("clear line ignored");
  a_own_terms: assert property (
    mcSets[0] == 4'h0 |-> mcSum[0] == (t0[0] | t1[0]))
    else $error("expander leaked into sum");
  a_write_pulse: assert property (
    memMode && tickA && ceWr && wrStrobe && !wClr |=> state_r.wPend ##1 !state_r.wPend)
    else $error("write pulse not one cycle");
  a_out_pipe: assert property (
    outRegEn && oTick && ceRd && !oClr |=> rdData == $past(state_r.rWord))
    else $error("output stage wrong");
  a_page_drive: assert property (
    memMode && deepEn && rTick && rCe && readStrobe && !rClr
    |=> !memMode || !deepEn || rdDrive == ($past(rAddrIn[12:11]) == pageSel))
    else $error("page decode wrong");
  a_group_clear: assert property (
    portMode == emb_pkg::EMB_RW_CLOCK && clrRd |=> state_r.rWord == '0)
    else $error("read group not cleared");
  a_edge_pick: assert property (
    tickB == (lineFall[1] ? $fell(clkLineB) : $rose(clkLineB)))
    else $error("line B edge choice ignored");
  a_t_toggle: assert property (
    !memMode && mcType[0] == emb_pkg::EMB_REG_T && !mcClkSel[0] && tickA && ceA
    && mcSum[0] && clrLine == 2'h0 |=> state_r.mcQ[0] != $past(state_r.mcQ[0]))
    else $error("T register did not toggle");
  a_jk_toggle: assert property (
    !memMode && mcType[0] == emb_pkg::EMB_REG_JK && !mcClkSel[0] && tickA && ceA
    && t0[0] && t1[0] && clrLine == 2'h0 |=> state_r.mcQ[0] != $past(state_r.mcQ[0]))
    else $error("JK register did not toggle");
  a_sr_reset: assert property (
    !memMode && mcType[0] == emb_pkg::EMB_REG_SR && !mcClkSel[0] && tickA && ceA
    && !t0[0] && t1[0] && clrLine == 2'h0 |=> !state_r.mcQ[0])
    else $error("SR register did not reset");
  a_write_ce_hold: assert property (
    !ceWr && !wClr |=> $stable(state_r.wData) && !state_r.wPend)
    else $error("write group moved without enable");
  a_out_hold: assert property (
    !ceRd && !oClr |=> $stable(state_r.outWord))
    else $error("output group moved without enable");
  a_rw_read_clock: assert property (
    memMode && portMode == emb_pkg::EMB_RW_CLOCK && !tickB && !rClr
    |=> $stable(state_r.rWord))
    else $error("read group moved off read clock");
  a_io_out_clock: assert property (
    portMode == emb_pkg::EMB_IO_CLOCK && !tickB && !oClr |=> $stable(state_r.outWord))
    else $error("output group moved off output clock");
  a_single_addr: assert property (
    memMode && portMode == emb_pkg::EMB_SINGLE && tickA && ceWr && readStrobe && !rClr
    |=> state_r.rAddr == $past(wrAddr))
    else $error("single port read address wrong");
  a_drive_idle: assert property (
    !memMode |-> !rdDrive)
    else $error("shared line driven in product-term use");

  c_write_read: cover property (memMode && tickA && wrStrobe ##[1:8] rTick && readStrobe);
  c_deep_drive: cover property (memMode && deepEn && rdDrive);
  c_jk_toggle:  cover property (!memMode && mcType[0] == emb_pkg::EMB_REG_JK && tickA);
  c_fall_tick:  cover property (!memMode && lineFall[1] && tickB);
  c_sr_reset:   cover property (!memMode && mcType[0] == emb_pkg::EMB_REG_SR && tickA);

endmodule // emb_block_top

// [hw/emb_pkg.sv]
// Shared constants and types of the embedded memory and product-term block
package emb_pkg;

  typedef enum logic [1:0] {EMB_SINGLE, EMB_RW_CLOCK, EMB_IO_CLOCK} emb_port_e;
  typedef enum logic [2:0] {EMB_REG_D, EMB_REG_T, EMB_REG_JK, EMB_REG_SR, EMB_REG_BYPASS}
    emb_reg_e;

  localparam int          MACROCELLS = 16;
  localparam int          MAX_SETS   = 15;
  localparam int          DATA_W     = 16;
  localparam int          ADDR_W     = 13;
  localparam int          PAGE_W     = 11;
  localparam int          BLOCK_BITS = 2048;
  localparam logic [2:0]  MAX_ASPECT = 3'h4;
  localparam logic [10:0] FULL_MASK  = 11'h7ff;
  localparam logic [1:0]  CLR_NONE   = 2'h0;
  localparam logic [1:0]  CLR_LINE0  = 2'h1;
  localparam logic [1:0]  CLR_LINE1  = 2'h2;
  localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

// [verification/emb_user_logic.sv]
// Surrounding user logic that raises one-cycle block clock-line pulses
`timescale 1ns/10ps

module emb_user_logic (
  // Clock
  input  wire logic       clk,
  // Pulse request, bit 0 line A, bit 1 line B
  input  wire logic [1:0] req,
  // Block clock lines
  output logic            clkLineA,
  output logic            clkLineB
);
  // Lines rest low between pulses
  initial {clkLineB, clkLineA} = 2'h0;
  always @(negedge clk) begin
    {clkLineB, clkLineA} <= req;
  end
endmodule // emb_user_logic

// [verification/emb_block_top_tb.sv]
// Bench for the embedded memory and product-term block
`timescale 1ns/10ps

module emb_block_top_tb;
  logic clk, rst, memMode, outRegEn, deepEn, ceWr, ceRd, clrWr, clrRd, globalClr;
  logic wrStrobe, readStrobe, ceA, ceB, clkLineA, clkLineB, rdDrive;
  logic [1:0] req, pageSel, ptClr, ptClrInv, lineFall;
  logic [2:0] aspect;
  emb_pkg::emb_port_e portMode;
  logic [15:0] wrData, rdData, mcClkSel, mcInvEn, mcInvWhich, mcOut;
  logic [12:0] wrAddr, rdAddr;
  logic [15:0][1:0] ptTerm, mcClrSel;
  logic [15:0][2:0] mcType;
  logic [15:0][3:0] mcSets;
  int fail_count, checked, i;

  emb_user_logic u_user (.clk(clk), .req(req), .clkLineA(clkLineA), .clkLineB(clkLineB));

  emb_block_top u_dut (
    .clk(clk), .rst(rst), .clkLineA(clkLineA), .clkLineB(clkLineB), .lineFall(lineFall),
    .memMode(memMode), .portMode(portMode), .aspect(aspect), .outRegEn(outRegEn),
    .deepEn(deepEn), .pageSel(pageSel), .ceWr(ceWr), .ceRd(ceRd), .clrWr(clrWr),
    .clrRd(clrRd), .globalClr(globalClr), .wrData(wrData), .wrAddr(wrAddr),
    .wrStrobe(wrStrobe), .rdAddr(rdAddr), .readStrobe(readStrobe), .rdData(rdData),
    .rdDrive(rdDrive), .ceA(ceA), .ceB(ceB), .ptClr(ptClr), .ptClrInv(ptClrInv),
    .ptTerm(ptTerm), .mcType(mcType), .mcClkSel(mcClkSel), .mcClrSel(mcClrSel),
    .mcInvEn(mcInvEn), .mcInvWhich(mcInvWhich), .mcSets(mcSets), .mcOut(mcOut)
  );

  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input logic [1:0] which);
    @(negedge clk) req <= which;
    @(negedge clk) req <= 2'h0;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    wrAddr = a;
    wrData = d;
    wrStrobe = 1'b1;
    pulse(2'h1);
    wrStrobe = 1'b0;
  endtask

  task automatic rd(input logic [12:0] a, input logic [1:0] which);
    rdAddr = a;
    wrAddr = a;
    readStrobe = 1'b1;
    pulse(which);
    readStrobe = 1'b0;
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {rst, memMode, ceWr, ceRd, ceA, ceB} = 6'h3f;
    {outRegEn, deepEn, clrWr, clrRd, globalClr, wrStrobe, readStrobe} = 7'h0;
    {req, pageSel, ptClr, ptClrInv, aspect} = 11'h0;
    portMode = emb_pkg::EMB_SINGLE;
    lineFall = 2'h0;
    {wrData, mcClkSel, mcInvEn, mcInvWhich, wrAddr, rdAddr} = '0;
    {ptTerm, mcClrSel, mcSets} = '0;
    mcType = {16{3'h4}};
    fail_count = 0;
    checked = 0;
    repeat (5) @(negedge clk);
    chk(rdData, 16'h0);
    chk({15'h0, rdDrive}, 16'h1);
    rst = 1'b0;
    // Every shape, word masked to its width
    for (i = 0; i < 5; i++) begin
      aspect = 3'(i);
      wr(13'h5, 16'ha5c3);
      rd(13'h5, 2'h1);
      chk(rdData, 16'ha5c3 & (16'hffff >> (16 - (16 >> i))));
    end
    aspect = 3'h0;
    // Same word written and read together
    wr(13'h7, 16'h1111);
    wrData = 16'h2222;
    wrStrobe = 1'b1;
    rd(13'h7, 2'h1);
    wrStrobe = 1'b0;
    chk(rdData, 16'h1111);
    rd(13'h7, 2'h1);
    chk(rdData, 16'h2222);
    ceWr = 1'b0;
    wr(13'h7, 16'h3333);
    ceWr = 1'b1;
    rd(13'h7, 2'h1);
    chk(rdData, 16'h2222);
    clrWr = 1'b1;
    repeat (2) @(negedge clk);
    clrWr = 1'b0;
    chk(rdData, 16'h0);
    rd(13'h7, 2'h1);
    globalClr = 1'b1;
    repeat (2) @(negedge clk);
    globalClr = 1'b0;
    chk(rdData, 16'h0);
    // Read/write clock mode
    portMode = emb_pkg::EMB_RW_CLOCK;
    wr(13'h9, 16'h4242);
    ceWr = 1'b0;
    rd(13'h9, 2'h2);
    chk(rdData, 16'h4242);
    ceWr = 1'b1;
    wr(13'ha, 16'h5151);
    rd(13'ha, 2'h1);
    chk(rdData, 16'h4242);
    outRegEn = 1'b1;
    rd(13'ha, 2'h2);
    chk(rdData, 16'h4242);
    pulse(2'h2);
    chk(rdData, 16'h5151);
    clrRd = 1'b1;
    repeat (2) @(negedge clk);
    clrRd = 1'b0;
    chk(rdData, 16'h0);
    // Input/output clock mode
    {outRegEn, ceRd} = 2'h0;
    portMode = emb_pkg::EMB_IO_CLOCK;
    rd(13'h9, 2'h1);
    chk(rdData, 16'h4242);
    rd(13'ha, 2'h2);
    chk(rdData, 16'h4242);
    ceRd = 1'b1;
    // Deep array paging
    portMode = emb_pkg::EMB_RW_CLOCK;
    {deepEn, pageSel} = 3'h6;
    wr(13'h1003, 16'h7777);
    wr(13'h0003, 16'h8888);
    rd(13'h1003, 2'h2);
    chk(rdData, 16'h7777);
    chk({15'h0, rdDrive}, 16'h1);
    rd(13'h0003, 2'h2);
    chk({15'h0, rdDrive}, 16'h0);
    // Product-term use
    {memMode, deepEn} = 2'h0;
    for (i = 0; i < 16; i++) ptTerm[i] = 2'(i);
    @(negedge clk);
    chk(mcOut, 16'heeee);
    mcInvEn = 16'hffff;
    @(negedge clk);
    chk(mcOut, 16'hdddd);
    mcInvEn = 16'h0;
    ptTerm = '0;
    ptTerm[15] = 2'h2;
    mcSets[0] = 4'hf;
    @(negedge clk);
    chk(mcOut, 16'h8001);
    mcSets[0] = 4'he;
    @(negedge clk);
    chk(mcOut, 16'h8000);
    mcSets[0] = 4'h0;
    mcType = '0;
    ptTerm = {16{2'h1}};
    {mcClkSel, ceB} = 17'h1fe00;
    pulse(2'h1);
    chk(mcOut, 16'h00ff);
    pulse(2'h2);
    chk(mcOut, 16'h00ff);
    ceB = 1'b1;
    pulse(2'h2);
    chk(mcOut, 16'hffff);
    mcType = {16{3'h1}};
    pulse(2'h3);
    chk(mcOut, 16'h0000);
    mcType = '0;
    pulse(2'h3);
    mcClrSel = {{8{2'h2}}, {8{2'h1}}};
    ptClrInv = 2'h1;
    repeat (2) @(negedge clk);
    chk(mcOut, 16'hff00);
    ptClr = 2'h3;
    repeat (2) @(negedge clk);
    chk(mcOut, 16'h0000);
    // Line B on its falling edge: terms change between the two edges
    {ptClr, ptClrInv} = 4'h0;
    ptTerm = '0;
    lineFall = 2'h2;
    @(negedge clk) req <= 2'h3;
    @(negedge clk) req <= 2'h0;
    @(negedge clk) ptTerm = {16{2'h1}};
    repeat (2) @(negedge clk);
    chk(mcOut, 16'hff00);
    lineFall = 2'h0;
    mcType = {16{3'h2}};
    ptTerm = {16{2'h3}};
    pulse(2'h3);
    chk(mcOut, 16'h00ff);
    {ceA, ceB} = 2'h0;
    pulse(2'h3);
    chk(mcOut, 16'h00ff);
    {ceA, ceB} = 2'h3;
    mcType = {16{3'h3}};
    ptTerm = {{8{2'h1}}, {8{2'h2}}};
    pulse(2'h3);
    chk(mcOut, 16'hff00);
    final_report();
  end
endmodule // emb_block_top_tb
